// ---- hdl/rdt_block.sv ----
`timescale 1ns/1ps
module rdt_block
  import rdt_pkg::*;
#(
  parameter longint                  SENSE_PERIOD = SENSE_CYCLES,
  parameter logic [6:0]              HOT_RESET    = 7'h00,
  parameter logic [TEMP_W-1:0]       TEMP_RESET   = 10'h254
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire rdt_req_type           reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire rdt_time_type          clock_now,
  input  wire logic                  hour_tick,
  output logic                       hour_step_fwd,
  output logic                       hour_step_back,
  output logic                       daylight_applied_flag,
  input  wire logic                  temp_sense_enable,
  output logic                       sense_start,
  input  wire logic                  sense_done,
  input  wire logic [TEMP_W-1:0]     sense_value,
  output logic [TEMP_W-1:0]          temperature_code,
  input  wire logic [6:0]            cold_curvature_coeff,
  input  wire logic signed [NET_W-1:0] initial_correction,
  output logic signed [NET_W-1:0]    net_correction,
  input  wire logic [4:0]            trim_step_scale,
  input  wire logic [5:0]            final_analog_trim,
  input  wire logic [4:0]            final_digital_trim,
  output logic                       trim_consistent
);

  // ----------------------------------------------------------------
  // Calendar helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] bcd_to_bin(input logic [7:0] b);
    logic [6:0] tens;
    tens = 7'(b[7:4]);
    return 7'((tens << 3) + (tens << 1) + 7'(b[3:0]));
  endfunction

  // Hour byte as 0..23, read in the clock's current 12/24-hour mode.
  function automatic logic [4:0] to_hour24(input logic [7:0] h, input logic h24_mode);
    logic [4:0] h12;
    h12 = 5'(bcd_to_bin({3'h0, h[4:0]}));
    if (h24_mode) begin
      return 5'(bcd_to_bin({2'h0, h[5:0]}));
    end
    if (h12 == 5'h0c) begin
      return h[HOUR_PM_BIT] ? 5'h0c : 5'h00;
    end
    return h[HOUR_PM_BIT] ? 5'(h12 + 5'h0c) : h12;
  endfunction

  function automatic logic [4:0] month_days(input logic [6:0] mon, input logic leap);
    case (mon)
      7'h02:                      return leap ? 5'h1d : 5'h1c;
      7'h04, 7'h06, 7'h09, 7'h0b: return 5'h1e;
      default:                    return 5'h1f;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] start_month;
  logic [7:0] start_day_week;
  logic [7:0] start_date;
  logic [7:0] start_hour;
  logic [7:0] end_month;
  logic [7:0] end_day_week;
  logic [7:0] end_date;
  logic [7:0] end_hour;
  logic [7:0] turnover_field;
  logic [7:0] hot_curvature_coeff;

  wire wr_start_month = reg_req.wr && reg_req.addr == ADDR_START_MONTH;
  wire daylight_enable_bit = start_month[ENABLE_BIT];
  wire enable_rise = wr_start_month && reg_req.wdata[ENABLE_BIT] && !daylight_enable_bit;
  wire enable_clear = wr_start_month && !reg_req.wdata[ENABLE_BIT];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_month         <= RESET_START_MON;
      start_day_week      <= RESET_ZERO;
      start_date          <= RESET_ZERO;
      start_hour          <= RESET_ZERO;
      end_month           <= RESET_END_MON;
      end_day_week        <= RESET_ZERO;
      end_date            <= RESET_ZERO;
      end_hour            <= RESET_ZERO;
      turnover_field      <= RESET_ZERO;
      hot_curvature_coeff <= {1'b0, HOT_RESET};
    end else if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_START_MONTH: start_month         <= reg_req.wdata & MASK_START_MONTH;
        ADDR_START_DW:    start_day_week      <= reg_req.wdata & MASK_DAY_WEEK;
        ADDR_START_DATE:  start_date          <= reg_req.wdata & MASK_DATE_HOUR;
        ADDR_START_HOUR:  start_hour          <= reg_req.wdata & MASK_DATE_HOUR;
        ADDR_END_MONTH:   end_month           <= reg_req.wdata & MASK_MONTH;
        ADDR_END_DW:      end_day_week        <= reg_req.wdata & MASK_DAY_WEEK;
        ADDR_END_DATE:    end_date            <= reg_req.wdata & MASK_DATE_HOUR;
        ADDR_END_HOUR:    end_hour            <= reg_req.wdata & MASK_DATE_HOUR;
        ADDR_TURNOVER:    turnover_field      <= reg_req.wdata & MASK_TURNOVER;
        ADDR_HOT_COEFF:   hot_curvature_coeff <= reg_req.wdata & MASK_HOT_COEFF;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    unique case (reg_req.addr)
      ADDR_START_MONTH: next_rdata = start_month;
      ADDR_START_DW:    next_rdata = start_day_week;
      ADDR_START_DATE:  next_rdata = start_date;
      ADDR_START_HOUR:  next_rdata = start_hour;
      ADDR_END_MONTH:   next_rdata = end_month;
      ADDR_END_DW:      next_rdata = end_day_week;
      ADDR_END_DATE:    next_rdata = end_date;
      ADDR_END_HOUR:    next_rdata = end_hour;
      ADDR_TEMP_LOW:    next_rdata = temperature_code[7:0];
      ADDR_TEMP_HIGH:   next_rdata = {6'h00, temperature_code[TEMP_W-1:8]};
      ADDR_TURNOVER:    next_rdata = turnover_field;
      ADDR_HOT_COEFF:   next_rdata = hot_curvature_coeff;
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Schedule matching
  // ----------------------------------------------------------------
  wire [6:0] now_month = bcd_to_bin(clock_now.month);
  wire [6:0] now_date  = bcd_to_bin(clock_now.date);
  wire [6:0] now_year  = bcd_to_bin(clock_now.year);
  wire       now_24h   = clock_now.hour[CLOCK_24H_BIT];
  wire [4:0] now_hour  = to_hour24(clock_now.hour, now_24h);
  wire       now_leap  = now_year[1:0] == 2'h0;
  wire [4:0] now_mdays = month_days(now_month, now_leap);
  wire [6:0] now_week  = 7'((7'(now_date - 7'h01) / 7'h07) + 7'h01);
  wire       now_last  = 7'(now_date + 7'h07) > 7'(now_mdays);

  // Day of the schedule, by weekday/week or by date as the priority bit picks.
  function automatic logic day_match(input logic [7:0] mon, input logic [7:0] dw, input logic [7:0] dt);
    logic week_ok;
    week_ok = (dw[5:3] == WEEK_LAST) ? now_last : (7'(dw[5:3]) == now_week);
    if (bcd_to_bin({3'h0, mon[4:0]}) != now_month) begin
      return 1'b0;
    end
    if (dw[PRIORITY_BIT]) begin
      return week_ok && dw[2:0] == clock_now.weekday;
    end
    return bcd_to_bin({2'h0, dt[5:0]}) == now_date;
  endfunction

  wire       start_day  = day_match(start_month, start_day_week, start_date);
  wire       end_day    = day_match(end_month, end_day_week, end_date);
  wire [4:0] start_h24  = to_hour24(start_hour, now_24h);
  wire [4:0] end_h24    = to_hour24(end_hour, now_24h);
  wire       start_near = start_day && (now_hour == start_h24 || 5'(now_hour + 5'h01) == start_h24);
  wire       end_near   = end_day && (now_hour == end_h24 || 5'(now_hour + 5'h01) == end_h24);
  wire       start_hit  = hour_tick && start_day && now_hour == start_h24;
  wire       end_hit    = hour_tick && end_day && now_hour == end_h24;

  // ----------------------------------------------------------------
  // Daylight saving sequencer
  // ----------------------------------------------------------------
  logic start_armed;
  logic end_armed;

  wire do_forward = daylight_enable_bit && start_armed && start_hit && !daylight_applied_flag;
  wire do_back    = daylight_enable_bit && end_armed && end_hit && daylight_applied_flag;

  // A schedule that is less than one hour away when enabled is skipped
  // until its day has passed.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_armed <= 1'b0;
      end_armed   <= 1'b0;
    end else if (enable_rise) begin
      start_armed <= !start_near;
      end_armed   <= !end_near;
    end else begin
      start_armed <= start_armed || !start_day;
      end_armed   <= end_armed || !end_day;
    end
  end

  // The hardware set wins over a clear by the enable write in the same cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      daylight_applied_flag <= 1'b0;
    end else if (do_forward) begin
      daylight_applied_flag <= 1'b1;
    end else if (do_back || enable_clear) begin
      daylight_applied_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hour_step_fwd  <= 1'b0;
      hour_step_back <= 1'b0;
    end else begin
      hour_step_fwd  <= do_forward;
      hour_step_back <= do_back;
    end
  end

  // ----------------------------------------------------------------
  // Temperature sensing
  // ----------------------------------------------------------------
  localparam int SENSE_W = $clog2(SENSE_PERIOD + 1);
  localparam logic [SENSE_W-1:0] SENSE_LAST = SENSE_W'(SENSE_PERIOD - 1);

  logic [SENSE_W-1:0] sense_count;
  logic [TEMP_W-1:0]  last_sample;
  logic               have_sample;

  wire               sense_due = temp_sense_enable && sense_count == SENSE_LAST;
  wire [TEMP_W:0]    sample_sum = (TEMP_W+1)'(last_sample) + (TEMP_W+1)'(sense_value);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sense_count <= '0;
      sense_start <= 1'b0;
    end else begin
      sense_start <= sense_due;
      if (!temp_sense_enable || sense_due) begin
        sense_count <= '0;
      end else begin
        sense_count <= SENSE_W'(sense_count + 1'b1);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_sample      <= '0;
      have_sample      <= 1'b0;
      temperature_code <= TEMP_RESET;
    end else if (!temp_sense_enable) begin
      have_sample <= 1'b0;
    end else if (sense_done) begin
      last_sample <= sense_value;
      have_sample <= 1'b1;
      if (have_sample) begin
        temperature_code <= sample_sum[TEMP_W:1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Compensation datapath
  // ----------------------------------------------------------------
  wire [11:0] turnover_mag = {8'h00, turnover_field[3:0]};
  wire [11:0] turnover_reference = turnover_field[TURNOVER_SIGN_BIT] ?
                                   12'(TURNOVER_BASE - turnover_mag) :
                                   12'(TURNOVER_BASE + turnover_mag);
  wire        is_hot       = {2'h0, temperature_code} > turnover_reference;
  wire [6:0]  curvature    = is_hot ? hot_curvature_coeff[6:0] : cold_curvature_coeff;
  wire signed [12:0] temp_delta = $signed({3'h0, temperature_code}) - $signed({1'b0, turnover_reference});
  wire [12:0] delta_mag    = temp_delta[12] ? 13'(-temp_delta) : 13'(temp_delta);
  wire [25:0] delta_sq     = delta_mag * delta_mag;
  wire [32:0] curve_prod   = 33'(curvature) * 33'(delta_sq);
  wire [20:0] curve_term   = 21'(curve_prod >> CURVE_SHIFT);
  wire signed [21:0] thermal_correction = $signed({1'b0, curve_term});
  wire signed [21:0] next_net = 22'(initial_correction) + thermal_correction;

  // Prediction from the final trims: 2 * (scale * analog - (digital - 16)).
  wire signed [15:0] trim_prod  = $signed({5'h00, 11'(trim_step_scale * final_analog_trim)});
  wire signed [15:0] trim_dig   = $signed({8'h00, 3'h0, final_digital_trim}) - $signed({8'h00, TRIM_OFFSET});
  wire signed [15:0] trim_net   = 16'((trim_prod - trim_dig) <<< 1);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      net_correction  <= '0;
      trim_consistent <= 1'b0;
    end else begin
      net_correction  <= NET_W'(next_net);
      trim_consistent <= NET_W'(next_net) == trim_net;
    end
  end

endmodule

// ---- hdl/rdt_pkg.sv ----
package rdt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_START_MONTH = 8'h20;
  localparam logic [7:0] ADDR_START_DW    = 8'h21;
  localparam logic [7:0] ADDR_START_DATE  = 8'h22;
  localparam logic [7:0] ADDR_START_HOUR  = 8'h23;
  localparam logic [7:0] ADDR_END_MONTH   = 8'h24;
  localparam logic [7:0] ADDR_END_DW      = 8'h25;
  localparam logic [7:0] ADDR_END_DATE    = 8'h26;
  localparam logic [7:0] ADDR_END_HOUR    = 8'h27;
  localparam logic [7:0] ADDR_TEMP_LOW    = 8'h28;
  localparam logic [7:0] ADDR_TEMP_HIGH   = 8'h29;
  localparam logic [7:0] ADDR_TURNOVER    = 8'h2c;
  localparam logic [7:0] ADDR_HOT_COEFF   = 8'h2d;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_START_MONTH = 8'h9f;
  localparam logic [7:0] MASK_MONTH       = 8'h1f;
  localparam logic [7:0] MASK_DAY_WEEK    = 8'h7f;
  localparam logic [7:0] MASK_DATE_HOUR   = 8'h3f;
  localparam logic [7:0] MASK_TURNOVER    = 8'h1f;
  localparam logic [7:0] MASK_HOT_COEFF   = 8'h7f;
  localparam logic [7:0] RESET_START_MON  = 8'h00;
  localparam logic [7:0] RESET_END_MON    = 8'h10;
  localparam logic [7:0] RESET_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT    = 7;
  localparam int PRIORITY_BIT  = 6;
  localparam int CLOCK_24H_BIT     = 7;
  localparam int HOUR_PM_BIT       = 5;
  localparam int TURNOVER_SIGN_BIT = 4;
  localparam logic [2:0] WEEK_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Compensation arithmetic
  // ----------------------------------------------------------------
  localparam int          TEMP_W        = 10;
  localparam int          NET_W         = 16;
  localparam logic [11:0] TURNOVER_BASE = 12'h254;
  localparam int          CURVE_SHIFT   = 12;
  localparam logic [7:0]  TRIM_OFFSET   = 8'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLOCK_HZ          = 100000000;
  localparam longint SENSE_INTERVAL_MS = 1000;
  localparam longint SENSE_CYCLES      = SENSE_INTERVAL_MS * CLOCK_HZ / 1000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [2:0] weekday;
    logic [7:0] hour;
  } rdt_time_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rdt_req_type;

endpackage

// ---- sim/rdt_block_props.sv ----
`timescale 1ns/1ps
module rdt_block_props
  import rdt_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire rdt_req_type       reg_req,
  input wire logic [7:0]        reg_rdata,
  input wire logic              hour_tick,
  input wire logic              hour_step_fwd,
  input wire logic              hour_step_back,
  input wire logic              daylight_applied_flag,
  input wire logic              temp_sense_enable,
  input wire logic              sense_start,
  input wire logic [TEMP_W-1:0] temperature_code,
  input wire logic              trim_consistent
);
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  logic [TEMP_W-1:0] prev_code;

  // Read data is taken from the code as it stood at the read edge.
  always_ff @(posedge ref_clk) begin
    prev_code <= temperature_code;
  end

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_fwd_sets_flag: assert property (hour_step_fwd |-> daylight_applied_flag && !$past(daylight_applied_flag))
    else $error("forward step without flag set");
  chk_back_clears_flag: assert property (hour_step_back
    |-> !daylight_applied_flag && $past(daylight_applied_flag))
    else $error("back step without flag clear");
  chk_step_one_cycle: assert property ((hour_step_fwd || hour_step_back) |=> !(hour_step_fwd || hour_step_back))
    else $error("hour step longer than one cycle");
  chk_step_has_tick: assert property ((hour_step_fwd || hour_step_back) |-> $past(hour_tick))
    else $error("hour step without hour tick");
  chk_flag_rise_cause: assert property ($rose(daylight_applied_flag) |-> hour_step_fwd)
    else $error("flag rose without forward step");
  chk_enable_clear: assert property (reg_req.wr && reg_req.addr == ADDR_START_MONTH && !reg_req.wdata[ENABLE_BIT]
    && !hour_tick |=> !daylight_applied_flag)
    else $error("flag kept after enable cleared");
  chk_sense_idle: assert property (!temp_sense_enable ##1 !temp_sense_enable |-> !sense_start)
    else $error("conversion started while disabled");
  chk_code_frozen: assert property (!temp_sense_enable ##1 !temp_sense_enable |=> $stable(temperature_code))
    else $error("code changed while disabled");
  chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_temp_high_read: assert property (reg_req.rd && reg_req.addr == ADDR_TEMP_HIGH
    |=> reg_rdata == {6'h00, prev_code[9:8]})
    else $error("high temperature read wrong");
  chk_temp_low_read: assert property (reg_req.rd && reg_req.addr == ADDR_TEMP_LOW
    |=> reg_rdata == prev_code[7:0])
    else $error("low temperature read wrong");

  cover property (hour_step_fwd);
  cover property (hour_step_back);
  cover property (sense_start);
  cover property (trim_consistent);
endmodule

bind rdt_block rdt_block_props rdt_block_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .hour_tick(hour_tick), .hour_step_fwd(hour_step_fwd), .hour_step_back(hour_step_back),
  .daylight_applied_flag(daylight_applied_flag), .temp_sense_enable(temp_sense_enable),
  .sense_start(sense_start), .temperature_code(temperature_code), .trim_consistent(trim_consistent));

// ---- sim/rdt_block_tb.sv ----
`timescale 1ns/1ps
module rdt_block_tb import rdt_pkg::*; ;
  logic                     ref_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  rdt_req_type              reg_req;
  logic [7:0]               reg_rdata;
  rdt_time_type             clock_now;
  logic                     hour_tick, hour_step_fwd, hour_step_back, daylight_applied_flag;
  logic                     temp_sense_enable, sense_start, sense_done, trim_consistent;
  logic [TEMP_W-1:0]        sense_value, temperature_code;
  logic [6:0]               cold_curvature_coeff;
  logic signed [NET_W-1:0]  initial_correction, net_correction;
  logic [4:0]               trim_step_scale, final_digital_trim;
  logic [5:0]               final_analog_trim;
  int                       n_mismatch = 0;
  int                       total_checks = 0;
  logic [7:0] adr [11] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2c, 8'h2d, 8'h2a};
  logic [7:0] rst_val [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [11] = '{8'h9f, 8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h7f, 8'h3f, 8'h3f, 8'h1f, 8'h7f, 8'h00};
  logic [7:0] cfg [8] = '{8'h03, 8'h00, 8'h10, 8'h02, 8'h10, 8'h78, 8'h20, 8'h22};

  rdt_block #(.SENSE_PERIOD(16)) rdt_block_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .clock_now(clock_now), .hour_tick(hour_tick), .hour_step_fwd(hour_step_fwd),
    .hour_step_back(hour_step_back), .daylight_applied_flag(daylight_applied_flag),
    .temp_sense_enable(temp_sense_enable), .sense_start(sense_start), .sense_done(sense_done),
    .sense_value(sense_value), .temperature_code(temperature_code), .cold_curvature_coeff(cold_curvature_coeff),
    .initial_correction(initial_correction), .net_correction(net_correction), .trim_step_scale(trim_step_scale),
    .final_analog_trim(final_analog_trim), .final_digital_trim(final_digital_trim),
    .trim_consistent(trim_consistent));

  always #5 ref_clk = ~ref_clk;

  // ------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 reg_req.wr = 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1 reg_req.rd = 1'b0;
    check(name, 16'(exp), 16'(reg_rdata));
  endtask

  task automatic set_now(input logic [7:0] mo, dt, input logic [2:0] wd, input logic [7:0] hr);
    @(posedge ref_clk);
    #1 clock_now = '{year: 8'h24, month: mo, date: dt, weekday: wd, hour: hr};
  endtask

  task automatic dst_tick(input logic [7:0] mo, dt, input logic [2:0] wd, input logic [7:0] hr, input logic f, b);
    set_now(mo, dt, wd, hr);
    hour_tick = 1'b1;
    @(posedge ref_clk);
    #1 hour_tick = 1'b0;
    check("hour_step_fwd", 16'(f), 16'(hour_step_fwd));
    check("hour_step_back", 16'(b), 16'(hour_step_back));
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    while (sense_start !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("sense_start", 16'h0001, 16'(sense_start));
  endtask

  // Between conversions the result bus shows the inverse, not a stale value.
  task automatic sense_pulse(input logic [9:0] v);
    @(posedge ref_clk);
    #1 sense_done = 1'b1;
    sense_value = v;
    @(posedge ref_clk);
    #1 sense_done = 1'b0;
    sense_value = ~v;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic net_chk(input logic [15:0] exp, input logic tc);
    repeat (3) @(posedge ref_clk);
    #1 check("net_correction", exp, 16'(net_correction));
    check("trim_consistent", 16'(tc), 16'(trim_consistent));
  endtask

  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_regs();
    check("temperature reset", 16'h0254, 16'(temperature_code));
    for (int i = 0; i < 11; i++) rd_chk("reset value", adr[i], rst_val[i]);
    for (int i = 0; i < 11; i++) begin
      reg_wr(adr[i], 8'hff);
      rd_chk("write mask", adr[i], msk[i]);
    end
  endtask

  task automatic test_dst();
    for (int i = 0; i < 8; i++) reg_wr(adr[i], cfg[i]);
    set_now(8'h03, 8'h09, 3'h6, 8'h80);
    reg_wr(8'h20, 8'h83);
    dst_tick(8'h03, 8'h10, 3'h0, 8'h82, 1'b1, 1'b0);
    check("flag after start", 16'h0001, 16'(daylight_applied_flag));
    reg_wr(8'h20, 8'h03);
    check("flag after disable", 16'h0000, 16'(daylight_applied_flag));
    set_now(8'h03, 8'h10, 3'h0, 8'h81);
    reg_wr(8'h20, 8'h83);
    dst_tick(8'h03, 8'h10, 3'h0, 8'h82, 1'b0, 1'b0);
    dst_tick(8'h03, 8'h11, 3'h1, 8'h80, 1'b0, 1'b0);
    dst_tick(8'h03, 8'h10, 3'h0, 8'h82, 1'b1, 1'b0);
    dst_tick(8'h10, 8'h20, 3'h0, 8'h22, 1'b0, 1'b0);
    dst_tick(8'h10, 8'h27, 3'h0, 8'h22, 1'b0, 1'b1);
    check("flag after end", 16'h0000, 16'(daylight_applied_flag));
  endtask

  task automatic test_net_cold();
    reg_wr(8'h2c, 8'h00);
    reg_wr(8'h2d, 8'h46);
    net_chk(16'd84, 1'b1);
    final_digital_trim = 5'd5;
    net_chk(16'd84, 1'b0);
    reg_wr(8'h2c, 8'h0f);
    net_chk(16'd90, 1'b0);
  endtask

  task automatic test_sense();
    temp_sense_enable = 1'b1;
    wait_start();
    sense_pulse(10'h250);
    wait_start();
    sense_pulse(10'h25b);
    check("averaged code", 16'h0255, 16'(temperature_code));
    check("celsius", 16'd25, 16'((16'(temperature_code) >> 1) - 16'd273));
    rd_chk("temp low byte", 8'h28, 8'h55);
    rd_chk("temp high bits", 8'h29, 8'h02);
    temp_sense_enable = 1'b0;
    sense_pulse(10'h3ff);
    check("code while off", 16'h0255, 16'(temperature_code));
    temp_sense_enable = 1'b1;
    wait_start();
    sense_pulse(10'h300);
    check("first after enable", 16'h0255, 16'(temperature_code));
    wait_start();
    sense_pulse(10'h302);
    temp_sense_enable = 1'b0;
    check("second after enable", 16'h0301, 16'(temperature_code));
  endtask

  task automatic test_net_hot();
    net_chk(16'd510, 1'b0);
    reg_wr(8'h2c, 8'h11);
    net_chk(16'd601, 1'b0);
  endtask

  initial begin
    reg_req = '0;
    clock_now = '0;
    hour_tick = 1'b0;
    temp_sense_enable = 1'b0;
    sense_done = 1'b0;
    sense_value = 10'h000;
    cold_curvature_coeff = 7'h7f;
    initial_correction = 16'sd84;
    trim_step_scale = 5'd3;
    final_analog_trim = 6'd10;
    final_digital_trim = 5'd4;
    repeat (8) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    test_regs();
    test_dst();
    test_net_cold();
    test_sense();
    test_net_hot();
    finish_test();
  end

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule
